// [pcg_top.sv]
// Peripheral clock gating unit with AHB-Lite register slave
// Contract
// RULE1: Group 0 bit 10 enables the converter clock; zero disables it.
// RULE2: Group 0 bit 6 enables the two-wire bus clock; zero disables it.
// RULE3: Group 0 bits 5 and 4 enable serial comm 1 and 0 clocks.
// RULE4: Group 0 bits 3 and 2 enable serial periph 1 and 0 clocks.
// RULE5: Group 0 bit 0 enables the pulse modulator clock.
// RULE6: Software writes zero to bits 9-7 and 1 of group 0 registers.
// RULE7: Timer bits 14-12 enable interval timers 2, 1, 0.
// RULE8: Timer bits 7-4 enable quad timer B channels 3 to 0.
// RULE9: Timer bits 3-0 enable quad timer A channels 3 to 0.
// RULE10: Software writes zero to timer register bits 15 and 11-8.
// RULE11: Timer enable register sits at index D, resets to zero.
// RULE12: Without its stop-keep bit a peripheral loses its clock in Stop.
// RULE13: Stop-keep one keeps clock in Stop only if also enabled.
// RULE14: Interrupt from a peripheral running in Stop returns to Run.
// RULE15: Stop-keep bits 15-12 cover comparators B, A and DACs one, zero.
// RULE16: Stop-keep bit 10 covers converter, bit 6 the two-wire module.
// RULE17: Stop-keep bits 5 and 4 cover serial comm 1 and 0.
// RULE18: Accesses to a peripheral with gated clock take no effect.
// RULE19: Software disables peripherals not kept before entering Stop.
// RULE20: Software keeps the smallest needed set running in Stop.
// RULE21: Group 0 bits 15-12 enable comparators B, A and DACs one, zero.
// RULE22: Stop-keep bits 3, 2 cover serial periph 1, 0; bit 0 pulse mod.
// RULE23: Gated clocks switch without glitches or runt pulses.
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module pcg_top (
  // System
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Power mode
  input  wire logic               stop_req,
  input  wire logic [15:0]        grp0_irq,
  input  wire logic [15:0]        timer_irq,
  output logic                    in_stop,
  output logic                    wake_pulse,
  // Clock enables, also access qualifiers for peripheral buses
  output pcg_pkg::pcg_clk_en_t    clk_en
);
  import pcg_pkg::*;

  pcg_state_t  state;
  pcg_state_t  next_state;
  logic [15:0] run0;
  logic [15:0] run1;
  logic        addr_ok;
  logic        wake_hit;

  // Read decode, shared by the data phase mux and the checks below
  function automatic logic [31:0] pcg_read_word(
    input logic [7:0]  idx,
    input pcg_state_t  s,
    input logic [15:0] r0,
    input logic [15:0] r1
  );
    logic [31:0] w;
    w = '0;
    case (idx)
      PCG_IDX_CLK_EN0:   w[15:0] = s.clk_en0;
      PCG_IDX_TIMER_EN:  w[15:0] = s.timer_en;
      PCG_IDX_STOP_KEEP: w[15:0] = s.stop_keep0;
      PCG_IDX_RUN0:      w[15:0] = r0;
      PCG_IDX_RUN1:      w[15:0] = r1;
      PCG_IDX_MODE:      w[PCG_B_IN_STOP] = (s.mode == PCG_STOP);
      default:           w = '0;
    endcase
    return w;
  endfunction : pcg_read_word

  // Address phase qualifier; size is not checked, words only
  assign addr_ok = hsel & htrans[1] & hready;

  // Only peripherals still clocked can raise a wake-up
  assign wake_hit = |(grp0_irq & run0) | |(timer_irq & run1); // RULE14

  // Next-state logic: bus slave, register writes, power mode
  always_comb begin
    next_state      = state;
    next_state.wake = 1'b0;
    // Write data phase commits; reserved bits are dropped
    if (state.dp_wr) begin
      case (state.dp_idx)
        PCG_IDX_CLK_EN0: begin
          next_state.clk_en0 = hwdata[15:0] & PCG_MASK_GRP0; // RULE21
        end
        PCG_IDX_TIMER_EN: begin
          next_state.timer_en = hwdata[15:0] & PCG_MASK_TIMER; // RULE11
        end
        PCG_IDX_STOP_KEEP: begin
          next_state.stop_keep0 = hwdata[15:0] & PCG_MASK_GRP0; // RULE15
        end
        default: begin
          next_state.clk_en0 = state.clk_en0;
        end
      endcase
    end
    // Read data is fetched one cycle late so it sees a prior write
    next_state.dp_wr = 1'b0;
    if (state.dp_rd) begin
      next_state.rdata = pcg_read_word(state.dp_idx, state, run0, run1);
      next_state.ready = 1'b1;
      next_state.dp_rd = 1'b0;
    end
    if (addr_ok) begin
      next_state.dp_idx = haddr[PCG_IDX_MSB:PCG_IDX_LSB];
      next_state.dp_wr  = hwrite;
      next_state.dp_rd  = ~hwrite;
      next_state.ready  = hwrite;
    end
    // Power mode sequencing
    case (state.mode)
      PCG_RUN: begin
        if (stop_req) begin
          next_state.mode = PCG_STOP;
        end
      end
      PCG_STOP: begin
        if (wake_hit) begin
          next_state.mode = PCG_RUN; // RULE14
          next_state.wake = 1'b1;
        end
      end
      default: begin
        next_state.mode = PCG_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state            <= '0;
      state.clk_en0    <= PCG_RST_CLK_EN0;
      state.timer_en   <= PCG_RST_TIMER_EN; // RULE11
      state.stop_keep0 <= PCG_RST_STOP_KEEP;
      state.mode       <= PCG_RUN;
      state.ready      <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Group 0 gates: comparators, DACs, converter, serial, pulse mod
  pcg_gate_bank #(
    .WIDTH (16),
    .IMPL  (PCG_MASK_GRP0)
  ) u_grp0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (state.clk_en0), // RULE1 RULE2 RULE3 RULE4 RULE5 RULE21
    .keep    (state.stop_keep0), // RULE15 RULE16 RULE17 RULE22
    .in_stop (state.mode == PCG_STOP),
    .running (run0)
  );

  // Timer gates have no stop-keep control here, so stop always gates
  pcg_gate_bank #(
    .WIDTH (16),
    .IMPL  (PCG_MASK_TIMER)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .enable  (state.timer_en), // RULE7 RULE8 RULE9
    .keep    (16'h0000),
    .in_stop (state.mode == PCG_STOP),
    .running (run1)
  );

  // Outputs straight from flops, except hresp tied low and in_stop decoded from the mode flops
  assign hrdata     = state.rdata;
  assign hreadyout  = state.ready;
  assign hresp      = 1'b0;
  assign in_stop    = (state.mode == PCG_STOP);
  assign wake_pulse = state.wake;
  // A peripheral's bus strobes are qualified by its enable
  assign clk_en.grp0  = run0; // RULE18
  assign clk_en.timer = run1; // RULE18

  // Checks on the gating relations, power mode sequencing and register reads
  sequence s_rd_addr;
    addr_ok && !hwrite;
  endsequence

  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_converter_gate;
    @(posedge hclk) disable iff (!hresetn)
    run0[PCG_B_CONVERTER] == $past(state.clk_en0[PCG_B_CONVERTER] &&
      (state.mode == PCG_RUN || state.stop_keep0[PCG_B_CONVERTER]));
  endproperty
  a_converter_gate: assert property (p_converter_gate) // RULE1 RULE16
    else $error("converter clock enable mismatch");

  property p_twowire_gate;
    @(posedge hclk) disable iff (!hresetn)
    !state.clk_en0[PCG_B_TWOWIRE] |=> !run0[PCG_B_TWOWIRE];
  endproperty
  a_twowire_gate: assert property (p_twowire_gate) // RULE2
    else $error("two-wire clock runs while disabled");

  property p_serial_comm_gate;
    @(posedge hclk) disable iff (!hresetn)
    (state.mode == PCG_RUN && !stop_req) |=>
      run0[PCG_B_SERIAL_COMM_1:PCG_B_SERIAL_COMM_0] ==
      $past(state.clk_en0[PCG_B_SERIAL_COMM_1:PCG_B_SERIAL_COMM_0]);
  endproperty
  a_serial_comm_gate: assert property (p_serial_comm_gate) // RULE3
    else $error("serial comm clock does not follow enable in Run");

  property p_serial_periph_gate;
    @(posedge hclk) disable iff (!hresetn)
    state.mode == PCG_STOP && !state.stop_keep0[PCG_B_SERIAL_PERIPH_0]
      |=> !run0[PCG_B_SERIAL_PERIPH_0];
  endproperty
  a_serial_periph_gate: assert property (p_serial_periph_gate) // RULE4
    else $error("serial periph clock runs in Stop without keep");

  property p_pulse_mod_keep;
    @(posedge hclk) disable iff (!hresetn)
    (state.mode == PCG_STOP && state.stop_keep0[PCG_B_PULSE_MOD] &&
     state.clk_en0[PCG_B_PULSE_MOD]) |=> run0[PCG_B_PULSE_MOD];
  endproperty
  a_pulse_mod_keep: assert property (p_pulse_mod_keep) // RULE5 RULE13
    else $error("kept pulse modulator clock stopped in Stop");

  property p_timer_stop;
    @(posedge hclk) disable iff (!hresetn)
    (state.mode == PCG_STOP)[*2] |-> run1 == 16'h0000;
  endproperty
  a_timer_stop: assert property (p_timer_stop) // RULE12 RULE7
    else $error("timer clock runs in Stop");

  property p_reserved_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (run0 & ~PCG_MASK_GRP0) == 16'h0000 &&
    (run1 & ~PCG_MASK_TIMER) == 16'h0000;
  endproperty
  a_reserved_quiet: assert property (p_reserved_quiet) // RULE6 RULE10
    else $error("reserved position shows a running clock");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
    (state.mode == PCG_STOP && wake_hit) |=>
      (state.mode == PCG_RUN && wake_pulse) ##1 !wake_pulse;
  endproperty
  a_wake: assert property (p_wake) // RULE14
    else $error("wake-up interrupt did not return to Run");

  property p_read_word;
    logic [7:0] idx;
    @(posedge hclk) disable iff (!hresetn)
    (s_rd_addr, idx = haddr[PCG_IDX_MSB:PCG_IDX_LSB]) |=> s_rd_done
      ##0 hrdata == pcg_read_word(idx, state, run0, run1);
  endproperty
  a_read_word: assert property (p_read_word) // RULE11
    else $error("register read returned wrong data");

  property p_timer_run;
    @(posedge hclk) disable iff (!hresetn)
    state.mode == PCG_RUN |=> run1 == $past(state.timer_en);
  endproperty
  a_timer_run: assert property (p_timer_run) // RULE7 RULE8 RULE9
    else $error("timer clock does not follow enable in Run");

  // In Stop each group 0 clock runs only if enabled and kept
  property p_stop_keep_grp0;
    @(posedge hclk) disable iff (!hresetn)
    state.mode == PCG_STOP |=>
      run0 == $past(state.clk_en0 & state.stop_keep0);
  endproperty
  a_stop_keep_grp0: assert property (p_stop_keep_grp0) // RULE15 RULE17 RULE22
    else $error("group 0 Stop clocks differ from enable and keep");

  property p_stop_entry;
    @(posedge hclk) disable iff (!hresetn)
    (state.mode == PCG_RUN && stop_req) |=> in_stop;
  endproperty
  a_stop_entry: assert property (p_stop_entry) // RULE12
    else $error("stop request did not enter Stop");

  sequence s_timer_write;
    state.dp_wr && state.dp_idx == PCG_IDX_TIMER_EN;
  endsequence

  // Reserved timer bits never land, whatever software writes
  property p_timer_write;
    @(posedge hclk) disable iff (!hresetn)
    s_timer_write |=>
      state.timer_en == ($past(hwdata[15:0]) & PCG_MASK_TIMER);
  endproperty
  a_timer_write: assert property (p_timer_write) // RULE11
    else $error("timer enable write did not land");

  property p_wake_quiet;
    @(posedge hclk) disable iff (!hresetn)
    state.mode == PCG_RUN |=> !wake_pulse;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) // RULE14
    else $error("wake pulse raised outside Stop");

endmodule : pcg_top

// [pcg_pkg.sv]
// Package for the peripheral clock gating block: map, fields and types
package pcg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  PCG_IDX_CLK_EN0   = 8'h0c;
  localparam logic [7:0]  PCG_IDX_TIMER_EN  = 8'h0d;
  localparam logic [7:0]  PCG_IDX_STOP_KEEP = 8'h0e;
  localparam logic [7:0]  PCG_IDX_RUN0      = 8'h20;
  localparam logic [7:0]  PCG_IDX_RUN1      = 8'h21;
  localparam logic [7:0]  PCG_IDX_MODE      = 8'h22;

  // Word index sits in byte address bits 9:2
  localparam int          PCG_IDX_LSB       = 2;
  localparam int          PCG_IDX_MSB       = 9;

  // Reset values
  localparam logic [15:0] PCG_RST_CLK_EN0   = 16'h0000;
  localparam logic [15:0] PCG_RST_TIMER_EN  = 16'h0000;
  localparam logic [15:0] PCG_RST_STOP_KEEP = 16'h0000;

  // Writable bit masks; all other positions read as zero
  localparam logic [15:0] PCG_MASK_GRP0     = 16'hf47d;
  localparam logic [15:0] PCG_MASK_TIMER    = 16'h70ff;

  // Group 0 bit positions (enable and stop-keep share them)
  localparam int          PCG_B_COMPARATOR_B = 15;
  localparam int          PCG_B_COMPARATOR_A = 14;
  localparam int          PCG_B_DAC_ONE      = 13;
  localparam int          PCG_B_DAC_ZERO     = 12;
  localparam int          PCG_B_CONVERTER    = 10;
  localparam int          PCG_B_TWOWIRE      = 6;
  localparam int          PCG_B_SERIAL_COMM_1 = 5;
  localparam int          PCG_B_SERIAL_COMM_0 = 4;
  localparam int          PCG_B_SERIAL_PERIPH_1 = 3;
  localparam int          PCG_B_SERIAL_PERIPH_0 = 2;
  localparam int          PCG_B_PULSE_MOD    = 0;

  // Timer group bit positions
  localparam int          PCG_B_INTERVAL_TIMER_0 = 12;
  localparam int          PCG_B_QTIMER_B_CH0 = 4;
  localparam int          PCG_B_QTIMER_A_CH0 = 0;

  // Mode register field
  localparam int          PCG_B_IN_STOP     = 0;

  // System power mode
  typedef enum logic [1:0] {
    PCG_RUN  = 2'b00,
    PCG_STOP = 2'b01
  } pcg_mode_t;

  // Gated clock enables of both groups
  typedef struct packed {
    logic [15:0] grp0;
    logic [15:0] timer;
  } pcg_clk_en_t;

  // All state of the top module
  typedef struct packed {
    logic [15:0] clk_en0;
    logic [15:0] timer_en;
    logic [15:0] stop_keep0;
    pcg_mode_t   mode;
    logic        wake;
    logic        dp_wr;
    logic        dp_rd;
    logic [7:0]  dp_idx;
    logic [31:0] rdata;
    logic        ready;
  } pcg_state_t;

endpackage : pcg_pkg

// [pcg_gate_bank.sv]
// Bank of glitch-free registered clock enables for one peripheral group
`timescale 1ns/1ps
module pcg_gate_bank #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] IMPL  = 16'hffff
) (
  // System
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] keep,
  input  wire logic             in_stop,
  // Gated enables toward the clock gate cells
  output logic      [WIDTH-1:0] running
);
  import pcg_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] run;
  } pcg_bank_t;

  pcg_bank_t state;
  pcg_bank_t next_state;

  // One flop per peripheral; generate keeps the bit terms uniform
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    // Kept in Stop only while enabled and flagged to keep
    assign next_state.run[i] = IMPL[i] & enable[i] &
                               (~in_stop | keep[i]); // RULE12 RULE13
  end

  // Enables change only at hclk edges or on async reset, so the downstream gate cell
  // never sees a runt: its latch opens while the clock is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state; // RULE23
    end
  end

  assign running = state.run;

endmodule : pcg_gate_bank

// [pcg_top_tb.sv]
// Self-checking testbench for the peripheral clock gating unit
`timescale 1ns/1ps
module pcg_top_tb;
  import pcg_pkg::*;

  // One table row: register index, write data, expected read-back
  typedef struct packed {
    logic [7:0]  idx;
    logic [15:0] wd;
    logic [15:0] rexp;
  } pcg_tb_row_t;

  // Stimulus
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic               stop_req;
  logic [15:0]        grp0_irq;
  logic [15:0]        timer_irq;
  // Observed
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  logic               in_stop;
  logic               wake_pulse;
  pcg_clk_en_t        clk_en;
  // Bench state
  int                 fails;
  int                 total_checks;
  logic [15:0]        m0;
  logic [15:0]        mt;
  logic [31:0]        rd;

  // Literal indices so a wrong map in the design cannot hide
  pcg_tb_row_t rows [14] = '{
    '{8'h0c, 16'h0400, 16'h0400}, '{8'h0c, 16'h0040, 16'h0040},
    '{8'h0c, 16'h0030, 16'h0030}, '{8'h0c, 16'h000c, 16'h000c},
    '{8'h0c, 16'h0001, 16'h0001}, '{8'h0c, 16'hf000, 16'hf000},
    '{8'h0c, 16'h0382, 16'h0000}, '{8'h0d, 16'h7000, 16'h7000},
    '{8'h0d, 16'h00f0, 16'h00f0}, '{8'h0d, 16'h000f, 16'h000f},
    '{8'h0d, 16'h8f00, 16'h0000}, '{8'h0e, 16'hf47d, 16'hf47d},
    '{8'h0e, 16'h0b82, 16'h0000}, '{8'h0f, 16'hffff, 16'h0000}
  };

  pcg_top DUT (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hwdata     (hwdata),
    .hready     (hreadyout),
    .hrdata     (hrdata),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .stop_req   (stop_req),
    .grp0_irq   (grp0_irq),
    .timer_irq  (timer_irq),
    .in_stop    (in_stop),
    .wake_pulse (wake_pulse),
    .clk_en     (clk_en)
  );

  // 50 MHz system clock
  initial hclk = 1'b0;
  always #10 hclk = ~hclk;

  // Verdict and end of run; the only exit of the bench
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Single AHB-Lite transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd, output logic [31:0] rdo);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {22'h000000, idx, 2'b00};
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rdo = hrdata;
    if (hreadyout !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask : ahb

  // Main sequence
  initial begin
    hresetn      = 1'b0;
    hsel         = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'b00;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h0;
    stop_req     = 1'b0;
    grp0_irq     = 16'h0;
    timer_irq    = 16'h0;
    fails        = 0;
    total_checks = 0;
    m0           = 16'h0;
    mt           = 16'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1 check("clk_en at reset", 32'h0, clk_en);
    // Table: write, read back, then the clock enables
    for (int i = 0; i < 14; i++) begin
      ahb(1'b1, rows[i].idx, {16'h0, rows[i].wd}, rd);
      if (rows[i].idx == 8'h0c) m0 = rows[i].rexp;
      if (rows[i].idx == 8'h0d) mt = rows[i].rexp;
      ahb(1'b0, rows[i].idx, 32'h0, rd);
      check("read back", {16'h0, rows[i].rexp}, rd);
      check("hresp", 32'h0, {31'h0, hresp});
      check("clk_en run", {m0, mt}, clk_en);
    end
    // Stop entry: only enabled and kept clocks keep running
    ahb(1'b1, 8'h0c, 32'h0470, rd);
    ahb(1'b1, 8'h0e, 32'h1410, rd);
    ahb(1'b1, 8'h0d, 32'h1001, rd);
    repeat (2) @(posedge hclk);
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
    #1 check("in_stop", 32'h1, {31'h0, in_stop});
    @(posedge hclk);
    #1 check("clk_en stop", 32'h0410_0000, clk_en);
    ahb(1'b0, 8'h22, 32'h0, rd);
    check("mode reg", 32'h1, rd);
    ahb(1'b0, 8'h20, 32'h0, rd);
    check("running grp0", 32'h0410, rd);
    ahb(1'b0, 8'h21, 32'h0, rd);
    check("running timer", 32'h0, rd);
    // Interrupts from stopped clocks must not wake
    @(posedge hclk);
    grp0_irq  <= 16'h0060;
    timer_irq <= 16'h1001;
    repeat (3) @(posedge hclk);
    #1 check("no wake", 32'h2, {30'h0, in_stop, wake_pulse});
    @(posedge hclk);
    grp0_irq  <= 16'h0400;
    timer_irq <= 16'h0;
    @(posedge hclk);
    #1 check("wake", 32'h1, {30'h0, in_stop, wake_pulse});
    @(posedge hclk);
    grp0_irq <= 16'h0;
    #1 check("clk_en back", 32'h0470_1001, clk_en);
    check("wake pulse", 32'h0, {31'h0, wake_pulse});
    // Reset in mid-run clears everything
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1 check("clk_en reset", 32'h0, clk_en);
    @(posedge hclk);
    hresetn <= 1'b1;
    for (int r = 12; r < 15; r++) begin
      ahb(1'b0, r[7:0], 32'h0, rd);
      check("reset value", 32'h0, rd);
    end
    finish_test();
  end

endmodule : pcg_top_tb
